// >>> verilog/rcd_defs.svh
/*
 * Constants of the rc oscillator divider and trim protect block: register
 * indices, field positions, reset values and division codes.
 * Assumes it is included once by the package and by the top module.
 */
//
// Summary of operation
// R1 - new divider ratio applies right after write
// R2 - ratio bits writable only while switch flag 0
// R3 - select 0X undivided, 10 by two, 11 by four
// R4 - trim writes need lock 0 and enable 1
// R5 - enable sets: wrote 1, key 0, protect 1
// R6 - enable clears on reset or key-0 write-0 with protect 1
// R7 - eight-bit trim value, rewritable by software
// R8 - protect off keeps trim enable unchanged
`ifndef RCD_DEFS_SVH
`define RCD_DEFS_SVH

// ----------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RCD_IDX_CTRL 2'h0
`define RCD_IDX_PROT 2'h1
`define RCD_IDX_TRIM 2'h2
`define RCD_IDX_FREE 2'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCD_CTRL_SEL_HI 1
`define RCD_CTRL_SEL_LO 0
`define RCD_PROT_PROTECT_WR_EN 7
`define RCD_PROT_WR_INHIBIT 6
`define RCD_PROT_LOCK 5
`define RCD_PROT_TWE 4

// ----------------------------------------------------------------
// reset values and division codes
// ----------------------------------------------------------------
`define RCD_SEL_RESET 2'h0
`define RCD_TRIM_RESET 8'h80
`define RCD_SEL_DIV2 2'h2
`define RCD_SEL_DIV4 2'h3
`define RCD_CNT_ZERO 2'h0

`endif

// >>> verilog/rcd_pkg.sv
/*
 * Types of the rc oscillator divider and trim protect block.
 * Assumes rcd_defs.svh is on the include path.
 */
`include "rcd_defs.svh"

package rcd_pkg;

	// ----------------------------------------------------------------
	// whole state of the top module
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wait_q;
		logic [7:0] rdata_q;
		logic [1:0] div_sel_q;
		logic [1:0] cnt_q;
		logic osc_en_q;
		logic protect_write_enable_q;
		logic lock_q;
		logic twe_q;
		logic [7:0] trim_q;
	} rcd_state_type;

endpackage : rcd_pkg

// >>> verilog/rcd_top.sv
/*
 * Rc oscillator divider select and trim value write protection, reached
 * over an Avalon-MM slave with waitrequest.
 * Assumes clock_switch_flag comes from clock switch logic on ref_clk.
 */
`timescale 1ns/100ps
`include "rcd_defs.svh"

module rcd_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// clock switch status
	input wire logic clock_switch_flag,
	// oscillator side
	output logic osc_clk_en,
	output logic [1:0] osc_div_select,
	output logic [7:0] osc_trim_value
);

	rcd_pkg::rcd_state_type s_q;
	rcd_pkg::rcd_state_type s_d;
	// decoded strobes, all but trim_open and wb qualified by the acknowledge cycle
	logic commit;
	logic wr_ok;
	logic wr_ctrl;
	logic wr_prot;
	logic wr_trim;
	logic trim_open;
	logic [7:0] wb;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// a request commits only in the cycle waitrequest stands low
	assign commit = (avs_read | avs_write) & ~s_q.wait_q;
	assign wr_ok = commit & avs_write & avs_byteenable[0];
	assign wr_ctrl = wr_ok & (avs_address == `RCD_IDX_CTRL);
	assign wr_prot = wr_ok & (avs_address == `RCD_IDX_PROT);
	assign wr_trim = wr_ok & (avs_address == `RCD_IDX_TRIM);
	assign wb = avs_writedata[7:0];
	assign trim_open = ~s_q.lock_q & s_q.twe_q; // [R4]

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// one wait cycle, then a single acknowledge cycle
		s_d.wait_q = ~((avs_read | avs_write) & s_q.wait_q);
		if ((avs_read | avs_write) & s_q.wait_q) begin
			unique case (avs_address)
				`RCD_IDX_CTRL: s_d.rdata_q = {6'h00, s_q.div_sel_q};
				`RCD_IDX_PROT: s_d.rdata_q = {s_q.protect_write_enable_q, 1'b0, s_q.lock_q, s_q.twe_q, 4'h0}; // key reads 0
				`RCD_IDX_TRIM: s_d.rdata_q = s_q.trim_q;
				default: s_d.rdata_q = 8'h00; // unmapped reads zero
			endcase
		end
		// ratio bits frozen while a clock switch is in progress
		if (wr_ctrl && !clock_switch_flag) begin
			s_d.div_sel_q = wb[`RCD_CTRL_SEL_HI:`RCD_CTRL_SEL_LO]; // [R2]
		end
		// protect register: key decisions use the protect bit already held
		if (wr_prot) begin
			s_d.protect_write_enable_q = wb[`RCD_PROT_PROTECT_WR_EN];
			if (s_q.protect_write_enable_q) begin // [R8]
				if (!wb[`RCD_PROT_WR_INHIBIT]) begin
					s_d.twe_q = wb[`RCD_PROT_TWE]; // [R5] [R6]
				end
				// lock only ever sets here; reset alone clears it
				s_d.lock_q = s_q.lock_q | wb[`RCD_PROT_LOCK];
			end
		end
		if (wr_trim && trim_open) begin
			s_d.trim_q = wb; // [R4] [R7]
		end
		// divider counts from the new select at once, no resync
		// the counter is never restarted, so a ratio change may shorten one gap
		s_d.cnt_q = s_q.cnt_q + 2'h1;
		unique case (s_d.div_sel_q) // [R1]
			`RCD_SEL_DIV2: s_d.osc_en_q = ~s_d.cnt_q[0]; // [R3]
			`RCD_SEL_DIV4: s_d.osc_en_q = (s_d.cnt_q == `RCD_CNT_ZERO); // [R3]
			default: s_d.osc_en_q = 1'b1; // [R3]
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q.wait_q <= 1'b1;
			s_q.rdata_q <= 8'h00;
			s_q.div_sel_q <= `RCD_SEL_RESET;
			s_q.cnt_q <= `RCD_CNT_ZERO;
			s_q.osc_en_q <= 1'b0;
			// protect, lock and enable fall together so reset always reshuts the trim
			s_q.protect_write_enable_q <= 1'b0;
			s_q.lock_q <= 1'b0;
			s_q.twe_q <= 1'b0; // [R6]
			s_q.trim_q <= `RCD_TRIM_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs are flop bits only
	assign avs_readdata = {24'h000000, s_q.rdata_q};
	assign avs_waitrequest = s_q.wait_q;
	assign osc_clk_en = s_q.osc_en_q;
	assign osc_div_select = s_q.div_sel_q;
	assign osc_trim_value = s_q.trim_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// all checks share ref_clk and are off while nrst holds the block
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// every request sees exactly one wait cycle, then one acknowledge
	AST_ACK_AFTER_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not acknowledged after one wait");
	AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("acknowledge longer than one cycle");
	// an idle bus keeps waitrequest high so a late request never commits early
	AST_IDLE_WAIT: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("acknowledge without request");
	// reads leave the select, the trim value and the trim enable as they were
	AST_READ_NO_EFFECT: assert property (commit && avs_read && !avs_write |=>
		$stable(osc_div_select) && $stable(osc_trim_value) && $stable(s_q.twe_q))
		else $error("read changed state");
	// refused writes: unmapped word and low lane off
	AST_FREE_WR_IGNORED: assert property (wr_ok && avs_address == `RCD_IDX_FREE |=>
		$stable(osc_div_select) && $stable(osc_trim_value) && $stable(s_q.twe_q))
		else $error("unmapped write changed state");
	AST_LANE_IGNORED: assert property (commit && avs_write && !avs_byteenable[0] |=>
		$stable(osc_div_select) && $stable(osc_trim_value))
		else $error("write without low lane stored");

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// read data is loaded in the wait cycle from the value held then
	AST_RD_CTRL: assert property (avs_read && avs_waitrequest && avs_address == `RCD_IDX_CTRL |=>
		avs_readdata[`RCD_CTRL_SEL_HI:`RCD_CTRL_SEL_LO] == $past(osc_div_select))
		else $error("control readback wrong");
	AST_RD_TRIM: assert property (avs_read && avs_waitrequest && avs_address == `RCD_IDX_TRIM |=> // [R7]
		avs_readdata[7:0] == $past(osc_trim_value)) else $error("trim readback wrong");
	// the key bit is write only, so software never sees a stale key
	AST_RD_KEY_ZERO: assert property (avs_read && avs_waitrequest && avs_address == `RCD_IDX_PROT |=>
		!avs_readdata[`RCD_PROT_WR_INHIBIT]) else $error("key bit read back");
	AST_RD_FREE_ZERO: assert property (avs_read && avs_waitrequest && avs_address == `RCD_IDX_FREE |=>
		avs_readdata == 32'h00000000) else $error("unmapped read not zero");

	// ----------------------------------------------------------------
	// divider select and enable
	// ----------------------------------------------------------------
	AST_SEL_APPLIED: assert property (wr_ctrl && !clock_switch_flag |=> // [R1]
		osc_div_select == $past(wb[`RCD_CTRL_SEL_HI:`RCD_CTRL_SEL_LO])) else $error("select not applied");
	AST_SEL_FROZEN: assert property (wr_ctrl && clock_switch_flag |=> $stable(osc_div_select)) // [R2]
		else $error("select changed during switch");
	// nothing but a committed control write may move the select
	AST_SEL_ONLY_WR: assert property (!wr_ctrl |=> $stable(osc_div_select)) // [R2]
		else $error("select moved without write");
	// the enable pattern is checked against the held select, only in cycles without a control write
	AST_DIV1_STEADY: assert property (!osc_div_select[`RCD_CTRL_SEL_HI] && !wr_ctrl |=> osc_clk_en) // [R3]
		else $error("undivided enable dropped");
	AST_DIV_GAP: assert property (osc_clk_en && osc_div_select[`RCD_CTRL_SEL_HI] && !wr_ctrl // [R3]
		|=> !osc_clk_en) else $error("divided enable not gapped");
	AST_DIV2_PERIOD: assert property (!osc_clk_en && osc_div_select == `RCD_SEL_DIV2 && !wr_ctrl // [R3]
		|=> osc_clk_en)
		else $error("divide by two enable missed");
	AST_DIV4_PERIOD: assert property (osc_clk_en && osc_div_select == `RCD_SEL_DIV4 && !wr_ctrl // [R3]
		##1 !wr_ctrl [*3] |=> osc_clk_en) else $error("divide by four period wrong");

	// ----------------------------------------------------------------
	// trim value and its protection
	// ----------------------------------------------------------------
	AST_TRIM_BLOCK: assert property (wr_trim && !trim_open |=> $stable(osc_trim_value)) // [R4]
		else $error("blocked trim write stored");
	AST_TRIM_STORE: assert property (wr_trim && trim_open |=> osc_trim_value == $past(wb)) // [R7]
		else $error("trim write lost");
	AST_TRIM_ONLY_WR: assert property (!wr_trim |=> $stable(osc_trim_value)) // [R4]
		else $error("trim moved without write");
	// once locked, only reset opens the trim register again
	AST_LOCK_STICKY: assert property (s_q.lock_q |=> s_q.lock_q) // [R4]
		else $error("lock released without reset");
	AST_PROT_STORED: assert property (wr_prot |=> // [R5]
		s_q.protect_write_enable_q == $past(wb[`RCD_PROT_PROTECT_WR_EN])) else $error("protect bit not stored");
	AST_TWE_SET: assert property ($rose(s_q.twe_q) |-> $past(wr_prot && s_q.protect_write_enable_q // [R5]
		&& !wb[`RCD_PROT_WR_INHIBIT] && wb[`RCD_PROT_TWE])) else $error("enable set without key");
	AST_TWE_CLR: assert property ($fell(s_q.twe_q) |-> $past(wr_prot && s_q.protect_write_enable_q // [R6]
		&& !wb[`RCD_PROT_WR_INHIBIT] && !wb[`RCD_PROT_TWE])) else $error("enable cleared without key");
	AST_TWE_HOLD: assert property (wr_prot && !s_q.protect_write_enable_q |=> $stable(s_q.twe_q)) // [R8]
		else $error("enable moved while unprotected");
	// a write with the key bit high updates the protect bit and may set lock, but leaves the enable alone
	AST_KEY_HOLD: assert property (wr_prot && wb[`RCD_PROT_WR_INHIBIT] |=> $stable(s_q.twe_q)) // [R5]
		else $error("enable moved with key high");
	AST_TWE_ONLY_PROT: assert property (!wr_prot |=> $stable(s_q.twe_q)) // [R6]
		else $error("enable moved without protect write");

	// ----------------------------------------------------------------
	// coverage of the main scenarios
	// ----------------------------------------------------------------
	// trim opened and written, divide by four, frozen select, key and lock
	COV_TRIM_WRITE: cover property (wr_trim && trim_open);
	COV_DIV4: cover property (wr_ctrl && !clock_switch_flag && wb[`RCD_CTRL_SEL_HI:`RCD_CTRL_SEL_LO] == `RCD_SEL_DIV4);
	COV_SWITCH_BLOCK: cover property (wr_ctrl && clock_switch_flag);
	COV_TWE_SET: cover property ($rose(s_q.twe_q));
	COV_LOCKED: cover property ($rose(s_q.lock_q));

endmodule : rcd_top

// >>> bench/test_rcd_top.sv
/*
 * Self-checking bench for rcd_top: register walk, divider pulses, trim protect, reset.
 * Assumes rcd_top and rcd_defs.svh are compiled alongside; one 250 MHz clock.
 */
`timescale 1ns/100ps
`include "rcd_defs.svh"

module test_rcd_top;
	typedef struct packed {logic [1:0] a; logic [7:0] d; logic f; logic [7:0] e;} rcd_row_type;
	logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest, clock_switch_flag, osc_clk_en;
	logic [1:0] avs_address, osc_div_select;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [7:0] osc_trim_value;
	int bad_count, samples_checked, cnt;
	// address, written byte, switch flag, expected readback
	rcd_row_type rows [15] = '{'{2'h0, 8'h02, 1'b0, 8'h02}, '{2'h0, 8'h03, 1'b0, 8'h03},
		'{2'h0, 8'h01, 1'b1, 8'h03}, '{2'h0, 8'h01, 1'b0, 8'h01}, '{2'h2, 8'h5A, 1'b0, 8'h80},
		'{2'h1, 8'h90, 1'b0, 8'h80}, '{2'h1, 8'h90, 1'b0, 8'h90}, '{2'h2, 8'h5A, 1'b0, 8'h5A},
		'{2'h1, 8'hD0, 1'b0, 8'h90}, '{2'h1, 8'h80, 1'b0, 8'h80}, '{2'h2, 8'h33, 1'b0, 8'h5A},
		'{2'h1, 8'h90, 1'b0, 8'h90}, '{2'h1, 8'hB0, 1'b0, 8'hB0}, '{2'h2, 8'h33, 1'b0, 8'h5A},
		'{2'h3, 8'hFF, 1'b0, 8'h00}};

	rcd_top dut_u (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .clock_switch_flag, .osc_clk_en,
		.osc_div_select, .osc_trim_value);

	// ----------------------------------------------------------------
	// clock and shared tasks
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// request held until waitrequest is seen low; bounded so a dead slave ends the run
	task automatic bus(input logic [1:0] a, input logic w, input logic [7:0] d);
		int k;
		logic ws;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		k = 0;
		// waitrequest and read data are taken mid-cycle, as they stand at the coming edge
		do begin
			@(negedge ref_clk);
			ws = avs_waitrequest;
			rd = avs_readdata;
			@(posedge ref_clk);
			k++;
		end while (ws !== 1'b0 && k < 20);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 20) begin
			bad_count++;
			final_report();
		end
	endtask : bus

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, avs_read, avs_write, clock_switch_flag, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		repeat (5) @(posedge ref_clk);
		chk("sel", `RCD_SEL_RESET, osc_div_select);
		chk("trim", `RCD_TRIM_RESET, osc_trim_value);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			clock_switch_flag <= rows[i].f;
			bus(rows[i].a, 1'b1, rows[i].d);
			clock_switch_flag <= 1'b0;
			bus(rows[i].a, 1'b0, 8'h00);
			chk("read", rows[i].e, rd);
			if (rows[i].a == `RCD_IDX_CTRL) chk("sel", rows[i].e, osc_div_select);
			if (rows[i].a == `RCD_IDX_TRIM) chk("trim", rows[i].e, osc_trim_value);
		end
		// pulse count over eight cycles is phase free: 8, 8, 4, 2 per select code
		for (int s = 0; s < 4; s++) begin
			bus(`RCD_IDX_CTRL, 1'b1, 8'(s));
			@(posedge ref_clk);
			cnt = 0;
			repeat (8) begin
				@(negedge ref_clk);
				cnt += osc_clk_en;
			end
			chk("pulses", (s < 2) ? 8 : (s == 2) ? 4 : 2, cnt);
		end
		// a write without the low lane is refused, so the divide by four select stays
		@(posedge ref_clk);
		avs_byteenable <= 4'hE;
		bus(`RCD_IDX_CTRL, 1'b1, 8'h02);
		avs_byteenable <= 4'hF;
		chk("lane", `RCD_SEL_DIV4, osc_div_select);
		// mid-run reset drops lock and trim enable
		nrst <= 1'b0;
		@(posedge ref_clk);
		chk("trim", `RCD_TRIM_RESET, osc_trim_value);
		nrst <= 1'b1;
		bus(`RCD_IDX_PROT, 1'b0, 8'h00);
		chk("prot", 32'h0, rd);
		final_report();
	end
endmodule : test_rcd_top
